// file: saf_pkg.sv
`default_nettype none
package saf_pkg;
    // ----------------------------------------------------------------
    // Link protocol
    // ----------------------------------------------------------------
    localparam logic [2:0] ACK_OK = 3'h1;
    localparam logic [2:0] ACK_WAIT = 3'h2;
    localparam logic [2:0] ACK_FAULT = 3'h4;
    localparam logic [5:0] HDR_LAST = 6'h06;
    localparam logic [5:0] ACK_LAST = 6'h03;
    localparam logic [5:0] DATA_BITS = 6'h20;
    localparam logic [5:0] LINE_RESET_ONES = 6'h32;
    // ----------------------------------------------------------------
    // Link-side flags and abort word
    // ----------------------------------------------------------------
    localparam int STK_ORUN = 0;
    localparam int STK_CMP = 1;
    localparam int STK_WDERR = 2;
    localparam int DPST_READOK = 3;
    localparam int ABT_DROP = 0;
    localparam int ABT_CLR_LSB = 1;
    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_CLR = 8'h0c;
    localparam logic [7:0] REG_IRQ_EN = 8'h10;
    localparam int CTRL_VERIFY = 0;
    localparam int CTRL_ORUN = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [3:0] IRQ_RST = 4'h0;
    localparam int EV_PROTO = 0;
    localparam int EV_WDERR = 1;
    localparam int EV_CMP = 2;
    localparam int EV_FAULT = 3;
    typedef enum logic [2:0] {S_IDLE, S_HDR, S_TRN, S_ACK, S_RDAT, S_WDAT, S_ERR} saf_state_e;
endpackage
`default_nettype wire

// file: saf_port.sv
`default_nettype none
module saf_port
#(
    parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Value is arbitrary.
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Serial link
    input wire logic swclk_i,
    input wire logic swdio_i,
    output logic swdio_o,
    output logic swdio_oe_n_o,
    // Access port side
    output logic ap_req_o,
    output logic ap_we_o,
    output logic [1:0] ap_addr_o,
    output logic [31:0] ap_wdata_o,
    input wire logic ap_done_i,
    input wire logic [31:0] ap_rdata_i,
    // Register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o
);
    import saf_pkg::*;

    // ----------------------------------------------------------------
    // Link input sampling
    // ----------------------------------------------------------------
    logic c1, c2, c3, clk_lvl, d1, d2, d3, din;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // The link clock idles high; starting high keeps a false edge out after reset.
            {c1, c2, c3, clk_lvl} <= 4'hf;
            {d1, d2, d3, din} <= 4'hf;
        end else begin
            {c1, c2, c3} <= {swclk_i, c1, c2};
            {d1, d2, d3} <= {swdio_i, d1, d2};
            if (c2 == c3) clk_lvl <= c3;
            if (d2 == d3) din <= d3;
        end
    end
    logic rise;
    assign rise = c2 & c3 & ~clk_lvl;

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------
    saf_state_e st;
    logic [5:0] cnt;
    logic [6:0] hdr, nh;
    logic [2:0] ack_q, stk, next_ack;
    logic [1:0] ctrl, rq_a;
    logic rq_ap, rq_rd, readok, pend_v, ap_out, hdr_ok, hdr_fire, wr_end, par_ok;
    logic [31:0] rsh, wsh, rdbuf, last_rd, next_rd;
    logic rpar;
    assign nh = {din, hdr[6:1]};
    assign hdr_ok = ~(^nh[4:0]) & ~nh[5] & nh[6];
    assign hdr_fire = rise && st == S_HDR && cnt == HDR_LAST;
    assign wr_end = rise && st == S_WDAT && cnt == DATA_BITS;
    assign par_ok = (^wsh) == din;

    always_comb begin
        if (!nh[0])
            next_ack = (|stk && nh[3]) ? ACK_FAULT : ACK_OK;
        else if (|stk)
            next_ack = ACK_FAULT;
        else if (nh[1])
            next_ack = (pend_v || ap_out) ? ACK_WAIT : ACK_OK;
        else
            next_ack = pend_v ? ACK_WAIT : ACK_OK;
    end

    always_comb begin
        next_rd = 32'h0;
        if (next_ack == ACK_OK) begin
            if (nh[0]) next_rd = rdbuf;
            else begin
                unique case (nh[3:2])
                    2'h0: next_rd = ID_VALUE;
                    2'h1: next_rd = {28'h0, readok, stk};
                    2'h2: next_rd = last_rd;
                    2'h3: next_rd = rdbuf;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Link sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st <= S_IDLE;
            cnt <= 6'h0;
            hdr <= 7'h0;
            ack_q <= ACK_OK;
            {rq_ap, rq_rd, rq_a} <= 4'h0;
            {swdio_o, swdio_oe_n_o} <= 2'h1;
            {rsh, wsh, last_rd} <= 96'h0;
            rpar <= 1'b0;
        end else if (rise) begin
            unique case (st)
                S_IDLE: begin
                    if (din) begin
                        st <= S_HDR;
                        cnt <= 6'h0;
                    end
                end
                S_HDR: begin
                    hdr <= nh;
                    cnt <= cnt + 6'h1;
                    if (cnt == HDR_LAST) begin
                        // A bad header leaves the line undriven.
                        st <= hdr_ok ? S_TRN : S_ERR;
                        cnt <= 6'h0;
                        ack_q <= next_ack;
                        {rq_a, rq_rd, rq_ap} <= nh[3:0];
                        rsh <= next_rd;
                        rpar <= ^next_rd;
                    end
                end
                S_TRN: begin
                    st <= S_ACK;
                    swdio_oe_n_o <= 1'b0;
                    swdio_o <= ack_q[0];
                    cnt <= 6'h1;
                end
                S_ACK: begin
                    if (cnt < ACK_LAST) begin
                        swdio_o <= ack_q[cnt[1:0]];
                        cnt <= cnt + 6'h1;
                    end else if (ack_q != ACK_OK && !ctrl[CTRL_ORUN]) begin
                        swdio_oe_n_o <= 1'b1;
                        st <= S_IDLE;
                    end else if (rq_rd) begin
                        swdio_o <= rsh[0];
                        rsh <= rsh >> 1;
                        last_rd <= rsh;
                        st <= S_RDAT;
                        cnt <= 6'h1;
                    end else begin
                        swdio_oe_n_o <= 1'b1;
                        st <= S_WDAT;
                        cnt <= 6'h0;
                    end
                end
                S_RDAT: begin
                    cnt <= cnt + 6'h1;
                    if (cnt < DATA_BITS) begin
                        swdio_o <= rsh[0];
                        rsh <= rsh >> 1;
                    end else if (cnt == DATA_BITS) begin
                        swdio_o <= rpar;
                    end else begin
                        swdio_oe_n_o <= 1'b1;
                        st <= S_IDLE;
                    end
                end
                S_WDAT: begin
                    // Parity is judged only here, after the acknowledge went out.
                    if (cnt < DATA_BITS) begin
                        wsh <= {din, wsh[31:1]};
                        cnt <= cnt + 6'h1;
                    end else begin
                        st <= S_IDLE;
                    end
                end
                S_ERR: begin
                    // Only a line reset, ones then a low bit, ends the lockout.
                    if (din) begin
                        if (cnt < LINE_RESET_ONES) cnt <= cnt + 6'h1;
                    end else if (cnt == LINE_RESET_ONES) begin
                        st <= S_IDLE;
                    end else begin
                        cnt <= 6'h0;
                    end
                end
                default: st <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Sticky flags and access port queue
    // ----------------------------------------------------------------
    logic wr_ok, abort, ap_rd_go, cmp_ev, wderr_ev, cur_cmp;
    logic pend_we, pend_cmp;
    logic [1:0] pend_a;
    logic [31:0] pend_d;
    assign wr_ok = wr_end && ack_q == ACK_OK && par_ok;
    assign wderr_ev = wr_end && ack_q == ACK_OK && !par_ok;
    assign abort = wr_ok && !rq_ap && rq_a == 2'h0;
    assign ap_rd_go = hdr_fire && hdr_ok && nh[0] && nh[1] && next_ack == ACK_OK;
    assign cmp_ev = ap_done_i && cur_cmp && ap_rdata_i != ap_wdata_o;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            stk <= 3'h0;
        end else begin
            stk <= (stk & ~(abort ? wsh[ABT_CLR_LSB +: 3] : 3'h0)) | {
                wderr_ev,
                cmp_ev,
                hdr_fire && hdr_ok && next_ack != ACK_OK && ctrl[CTRL_ORUN]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) readok <= 1'b0;
        else if (hdr_fire && hdr_ok && nh[0] && nh[1]) readok <= next_ack == ACK_OK;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            {pend_v, pend_we, pend_cmp, ap_out, ap_req_o, ap_we_o, cur_cmp} <= 7'h0;
            pend_a <= 2'h0;
            ap_addr_o <= 2'h0;
            {pend_d, ap_wdata_o, rdbuf} <= 96'h0;
        end else begin
            ap_req_o <= 1'b0;
            if (ap_done_i) begin
                ap_out <= 1'b0;
                if (!ap_we_o) rdbuf <= ap_rdata_i;
            end
            if (pend_v && !ap_out) begin
                ap_req_o <= 1'b1;
                ap_out <= 1'b1;
                pend_v <= 1'b0;
                ap_we_o <= pend_we;
                cur_cmp <= pend_cmp;
                ap_addr_o <= pend_a;
                ap_wdata_o <= pend_d;
            end
            if (ap_rd_go) begin
                {pend_v, pend_we, pend_cmp} <= 3'h4;
                pend_a <= nh[3:2];
            end else if (wr_ok && rq_ap) begin
                // Verify mode turns the write into a read that is compared.
                pend_v <= 1'b1;
                pend_we <= !ctrl[CTRL_VERIFY];
                pend_cmp <= ctrl[CTRL_VERIFY];
                pend_a <= rq_a;
                pend_d <= wsh;
            end else if (abort && wsh[ABT_DROP]) begin
                pend_v <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software registers and interrupt
    // ----------------------------------------------------------------
    logic [3:0] irq_st, irq_en, ev;
    assign ev = {hdr_fire && hdr_ok && next_ack == ACK_FAULT, cmp_ev, wderr_ev,
                 hdr_fire && !hdr_ok};

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RST;
            irq_en <= IRQ_RST;
        end else if (wr_i) begin
            if (addr_i == REG_CTRL) ctrl <= wdata_i[1:0];
            if (addr_i == REG_IRQ_EN) irq_en <= wdata_i[3:0];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_st <= IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            // A new event wins over a clear in the same cycle.
            irq_st <= (irq_st & ~((wr_i && addr_i == REG_IRQ_CLR) ? wdata_i[3:0] : 4'h0)) | ev;
            irq_o <= |(irq_st & irq_en);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i || !rd_i) rdata_o <= 32'h0;
        else begin
            unique case (addr_i)
                REG_CTRL: rdata_o <= {30'h0, ctrl};
                REG_STAT: rdata_o <= {26'h0, ap_out, pend_v, readok, stk};
                REG_IRQ_STAT: rdata_o <= {28'h0, irq_st};
                REG_IRQ_EN: rdata_o <= {28'h0, irq_en};
                default: rdata_o <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    property p_err_silent;
        hdr_fire && !hdr_ok |=> st == S_ERR ##0 swdio_oe_n_o [*4];
    endproperty
    a_err_silent: assert property (p_err_silent) else $error("driven after protocol error");

    property p_err_quiet;
        st == S_ERR |-> swdio_oe_n_o;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("line driven in lockout");

    property p_wderr_late;
        $rose(stk[STK_WDERR]) |-> $past(st) == S_WDAT && $past(cnt) == DATA_BITS;
    endproperty
    a_wderr_late: assert property (p_wderr_late) else $error("parity flag before data");

    property p_wderr_set;
        wderr_ev |=> stk[STK_WDERR];
    endproperty
    a_wderr_set: assert property (p_wderr_set) else $error("parity error not flagged");

    property p_verify_read;
        wr_ok && rq_ap && ctrl[CTRL_VERIFY] && !ap_out |=> ##[1:2] ap_req_o && !ap_we_o;
    endproperty
    a_verify_read: assert property (p_verify_read) else $error("verify not read");

    property p_buffered_issue;
        pend_v && !ap_out |=> ap_req_o && ap_out && !pend_v;
    endproperty
    a_buffered_issue: assert property (p_buffered_issue) else $error("queued write lost");

    property p_wait_no_data;
        rise && st == S_ACK && cnt == ACK_LAST && ack_q == ACK_WAIT && !ctrl[CTRL_ORUN]
            |=> st == S_IDLE && swdio_oe_n_o;
    endproperty
    a_wait_no_data: assert property (p_wait_no_data) else $error("data phase after wait");

    property p_orun_data;
        rise && st == S_ACK && cnt == ACK_LAST && ack_q != ACK_OK && ctrl[CTRL_ORUN]
            |=> st inside {S_RDAT, S_WDAT};
    endproperty
    a_orun_data: assert property (p_orun_data) else $error("overrun data phase missing");

    property p_fault_gate;
        hdr_fire && hdr_ok && |stk |=> ack_q == ((!rq_ap && !rq_a[1]) ? ACK_OK : ACK_FAULT);
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("fault gating wrong");

    c_fault: cover property (hdr_fire && next_ack == ACK_FAULT);
    c_buffered: cover property (wr_ok && rq_ap && ap_out);
    c_cmp_fail: cover property (cmp_ev);
    c_orun: cover property (st == S_WDAT && ack_q == ACK_WAIT);
endmodule // saf_port
`default_nettype wire

// file: saf_host_model.sv
`default_nettype none
module saf_host_model (
    // Link pins
    output logic swclk_o,
    output logic swdio_o,
    output logic swdio_oe_n_o,
    input wire logic swdio_i
);
    timeunit 1ns;
    timeprecision 100ps;
    import saf_pkg::*;
    // ------------------------------
    // Link bit and frame tasks
    // ------------------------------
    initial begin
        swclk_o = 1'b1;
        swdio_o = 1'b0;
        swdio_oe_n_o = 1'b0;
    end
    // Released data toggles so that a stale level never passes for an answer.
    task automatic cyc(input bit drv, input bit d, output logic s);
        swclk_o = 1'b0;
        swdio_oe_n_o = !drv;
        swdio_o = drv ? d : !swdio_o;
        #40;
        s = swdio_i;
        swclk_o = 1'b1;
        #40;
    endtask
    task automatic line_reset();
        logic s;
        repeat (52) cyc(1'b1, 1'b1, s);
        repeat (2) cyc(1'b1, 1'b0, s);
    endtask
    // The answer to a target select write is never decoded; the data phase always follows.
    task automatic tsel_write(input logic [31:0] wd);
        logic [7:0] h;
        logic s;
        h = {2'b10, 1'b0, 2'h3, 2'b00, 1'b1};
        for (int i = 0; i < 8; i++) cyc(1'b1, h[i], s);
        repeat (4) cyc(1'b0, 1'b0, s);
        for (int i = 0; i < 32; i++) cyc(1'b1, wd[i], s);
        cyc(1'b1, ^wd, s);
        repeat (2) cyc(1'b1, 1'b0, s);
    endtask
    // WAIT retries are bounded; past the limit the host aborts the queued work.
    task automatic xfer_retry(input bit ap, input bit rnw, input bit [1:0] a,
            input logic [31:0] wd, input int lim, output logic [2:0] ack, output int tries);
        logic [31:0] rd;
        logic pok;
        tries = 0;
        ack = ACK_WAIT;
        while (ack == ACK_WAIT && tries < lim) begin
            xfer(ap, rnw, a, wd, 3'h0, ack, rd, pok);
            tries++;
        end
        if (ack == ACK_WAIT) xfer(1'b0, 1'b0, 2'h0, 32'h1, 3'h0, ack, rd, pok);
    endtask
    // Mode m: bit 0 corrupts header parity, bit 1 data parity, bit 2 overrun detection on.
    task automatic xfer(input bit ap, input bit rnw, input bit [1:0] a, input logic [31:0] wd,
            input bit [2:0] m, output logic [2:0] ack, output logic [31:0] rd,
            output logic pok);
        logic [7:0] h;
        logic s;
        h = {2'b10, ^{a, rnw, ap} ^ m[0], a, rnw, ap, 1'b1};
        for (int i = 0; i < 8; i++) cyc(1'b1, h[i], s);
        cyc(1'b0, 1'b0, s);
        for (int i = 0; i < 3; i++) begin
            cyc(1'b0, 1'b0, s);
            ack[i] = s;
        end
        rd = 32'h0;
        pok = 1'b1;
        if (ack == ACK_OK || (m[2] && (ack == ACK_WAIT || ack == ACK_FAULT))) begin
            if (rnw) begin
                for (int i = 0; i < 32; i++) begin
                    cyc(1'b0, 1'b0, s);
                    rd[i] = s;
                end
                cyc(1'b0, 1'b0, s);
                pok = (s === ^rd);
            end else begin
                for (int i = 0; i < 32; i++) cyc(1'b1, wd[i], s);
                cyc(1'b1, ^wd ^ m[1], s);
            end
        end else if (ack != ACK_WAIT && ack != ACK_FAULT) begin
            repeat (33) cyc(1'b0, 1'b0, s);
        end
        repeat (2) cyc(1'b1, 1'b0, s);
    endtask
endmodule // saf_host_model
`default_nettype wire

// file: tb_saf_port.sv
`default_nettype none
module tb_saf_port;
    timeunit 1ns;
    timeprecision 100ps;
    import saf_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h5a3c_0001; // Value is arbitrary.
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic ap_done = 1'b0;
    logic ap_busy = 1'b0;
    logic [31:0] ap_val = 32'h0;
    logic swclk, host_d, host_oe_n, dev_d, dev_oe_n, ap_req, ap_we, irq, pok, last_we;
    logic [1:0] ap_a, last_a;
    logic [31:0] ap_wd, rdata, rdv, r, last_wd;
    logic [2:0] ack;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    int ap_wait = 4;
    int ap_cnt = 0;
    int req_n = 0;
    int drv_n = 0;
    wire logic line;
    // Pull-up on the shared data line.
    assign line = !dev_oe_n ? dev_d : (!host_oe_n ? host_d : 1'b1);
    saf_port #(.ID_VALUE(ID_VAL)) i_saf_port (.clk_sys_i(clk_sys), .rst_i(rst),
        .swclk_i(swclk), .swdio_i(line), .swdio_o(dev_d), .swdio_oe_n_o(dev_oe_n),
        .ap_req_o(ap_req), .ap_we_o(ap_we), .ap_addr_o(ap_a), .ap_wdata_o(ap_wd),
        .ap_done_i(ap_done), .ap_rdata_i(ap_val), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
    saf_host_model i_saf_host_model (.swclk_o(swclk), .swdio_o(host_d),
        .swdio_oe_n_o(host_oe_n), .swdio_i(line));
    always #2.5 clk_sys = ~clk_sys;
    // Access port stand-in: one access at a time, done ap_wait + 1 cycles after the request.
    always @(posedge clk_sys) begin
        ap_done <= 1'b0;
        cycles <= cycles + 1;
        if (!dev_oe_n) drv_n <= drv_n + 1;
        if (ap_req) begin
            ap_busy <= 1'b1;
            ap_cnt <= ap_wait;
            req_n <= req_n + 1;
            last_we <= ap_we;
            last_a <= ap_a;
            last_wd <= ap_wd;
        end else if (ap_busy && ap_cnt == 0) begin
            ap_busy <= 1'b0;
            ap_done <= 1'b1;
        end else if (ap_busy) begin
            ap_cnt <= ap_cnt - 1;
        end
        if (cycles == 60000) begin
            err_total++;
            $display("CHECK FAILED at %0t: timeout", $time);
            tally_and_finish();
        end
    end
    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic rwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rrd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic tx(input bit ap, input bit rnw, input bit [1:0] a, input logic [31:0] wd,
            input bit [2:0] m, input logic [2:0] exp);
        i_saf_host_model.xfer(ap, rnw, a, wd, m, ack, rdv, pok);
        chk(ack, exp, "ack");
    endtask
    task automatic set_ap(input int w, input logic [31:0] v);
        @(posedge clk_sys);
        ap_wait <= w;
        ap_val <= v;
    endtask
    task automatic idle_ap();
        for (int k = 0; k < 5000 && ap_busy; k++) @(posedge clk_sys);
        repeat (40) @(posedge clk_sys);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(irq, e, "irq");
    endtask
    task automatic stat_is(input logic [2:0] e);
        rrd(REG_STAT, r);
        chk(r[2:0], e, "sticky flags");
    endtask
    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_id();
        tx(1'b0, 1'b1, 2'h0, 32'h0, 3'h0, ACK_OK);
        chk(rdv, ID_VAL, "id data");
        chk(pok, 1'b1, "id parity");
    endtask
    task automatic t_buf();
        int n;
        int d;
        int tries;
        n = req_n;
        set_ap(5000, 32'h0);
        tx(1'b1, 1'b0, 2'h1, 32'ha5a5_0f0f, 3'h0, ACK_OK);
        chk({last_we, last_a}, 3'h5, "write kind");
        chk(last_wd, 32'ha5a5_0f0f, "write data");
        tx(1'b1, 1'b0, 2'h2, 32'h1234, 3'h0, ACK_OK);
        rrd(REG_STAT, r);
        chk(r[5:4], 2'h3, "queued behind busy");
        d = drv_n;
        tx(1'b1, 1'b0, 2'h3, 32'h0, 3'h0, ACK_WAIT);
        chk(drv_n - d > 40 && drv_n - d < 60, 1'b1, "ack only");
        i_saf_host_model.xfer_retry(1'b1, 1'b0, 2'h3, 32'h0, 2, ack, tries);
        chk(tries, 2, "wait retries bounded");
        chk(ack, ACK_OK, "escalated abort");
        rrd(REG_STAT, r);
        chk(r[4], 1'b0, "abort dropped queue");
        tx(1'b0, 1'b0, 2'h0, 32'h1, 3'h0, ACK_OK);
        idle_ap();
        chk(req_n, n + 1, "queued write abandoned");
        set_ap(4, 32'h0);
    endtask
    task automatic t_par();
        int n;
        n = req_n;
        tx(1'b1, 1'b0, 2'h0, 32'h0f0f_0001, 3'h2, ACK_OK);
        stat_is(3'h4);
        chk(req_n, n, "bad write dropped");
        tx(1'b1, 1'b1, 2'h0, 32'h0, 3'h0, ACK_FAULT);
        tx(1'b0, 1'b1, 2'h1, 32'h0, 3'h0, ACK_OK);
        chk(rdv[STK_WDERR], 1'b1, "link flag");
        tx(1'b0, 1'b1, 2'h2, 32'h0, 3'h0, ACK_FAULT);
        tx(1'b0, 1'b0, 2'h0, 32'h8, 3'h0, ACK_OK);
        stat_is(3'h0);
    endtask
    task automatic t_irq();
        rrd(REG_IRQ_STAT, r);
        chk(r, 32'ha, "event bits");
        rwr(REG_IRQ_EN, 32'h2);
        irq_is(1'b1);
        rwr(REG_IRQ_EN, 32'h1);
        irq_is(1'b0);
        rwr(REG_IRQ_CLR, 32'hf);
        rwr(REG_IRQ_EN, 32'hf);
        irq_is(1'b0);
    endtask
    task automatic t_proto();
        int d;
        d = drv_n;
        tx(1'b0, 1'b1, 2'h0, 32'h0, 3'h1, 3'h7);
        chk(drv_n, d, "never driven");
        irq_is(1'b1);
        i_saf_host_model.line_reset();
        i_saf_host_model.tsel_write(32'h0);
        t_id();
        rwr(REG_IRQ_CLR, 32'hf);
    endtask
    task automatic t_ver();
        rwr(REG_CTRL, 32'h1);
        set_ap(4, 32'h1111_0000);
        tx(1'b1, 1'b0, 2'h3, 32'h2222_0000, 3'h0, ACK_OK);
        chk({last_we, last_a}, 3'h3, "write became read");
        chk(last_wd, 32'h2222_0000, "compare value");
        idle_ap();
        stat_is(3'h2);
        tx(1'b0, 1'b0, 2'h0, 32'h4, 3'h0, ACK_OK);
        set_ap(4, 32'h2222_0000);
        tx(1'b1, 1'b0, 2'h3, 32'h2222_0000, 3'h0, ACK_OK);
        idle_ap();
        stat_is(3'h0);
        rwr(REG_CTRL, 32'h0);
    endtask
    task automatic t_orun();
        rwr(REG_CTRL, 32'h2);
        set_ap(3000, 32'h0);
        tx(1'b1, 1'b1, 2'h0, 32'h0, 3'h4, ACK_OK);
        tx(1'b1, 1'b1, 2'h0, 32'h0, 3'h4, ACK_WAIT);
        chk(rdv, 32'h0, "wait data");
        chk(pok, 1'b1, "wait parity");
        stat_is(3'h1);
        tx(1'b1, 1'b0, 2'h0, 32'h5, 3'h4, ACK_FAULT);
        t_id();
        tx(1'b0, 1'b0, 2'h0, 32'h2, 3'h4, ACK_OK);
        stat_is(3'h0);
        idle_ap();
        rwr(REG_CTRL, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rrd(8'hfc, r);
        chk(r, 32'h0, "unmapped read");
        chk(dev_oe_n, 1'b1, "released");
        t_id();
        t_buf();
        t_par();
        t_irq();
        t_proto();
        t_ver();
        t_orun();
        tally_and_finish();
    end
endmodule // tb_saf_port
`default_nettype wire
